// *** logic/ecp_ext_pkg.sv ***
// constants and carrier types for the extended control block
// assumes one 8-bit register port at offsets from the port base
package ecp_ext_pkg;
  localparam logic [10:0] OFS_CONFIG_A = 11'h400;
  localparam logic [10:0] OFS_CONFIG_B = 11'h401;
  localparam logic [10:0] OFS_EXT_CTRL = 11'h402;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int FAULT_EN_BIT = 4;
  localparam int DMA_EN_BIT = 3;
  localparam int SERVICE_BIT = 2;
  localparam int FULL_BIT = 1;
  localparam int EMPTY_BIT = 0;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic FAULT_EN_RESET = 1'b1;
  localparam logic DMA_EN_RESET = 1'b0;
  localparam logic SERVICE_RESET = 1'b1;
  localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
  localparam int FIFO_DEPTH = 16;
  localparam int PULSE_NS = 25;
  localparam int CLK_NS = 5;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    MODE_SPP, MODE_BIDIR, MODE_PFIFO, MODE_ECP,
    MODE_EPP, MODE_RSVD, MODE_TEST, MODE_CONFIG
  } mode_type;
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
  typedef struct packed {
    logic strobe_low;
    logic auto_feed_low;
    logic initialize_low;
    logic select_peripheral_low;
  } ctrl_lines_type;
endpackage : ecp_ext_pkg

// *** logic/ecp_ext_ctrl.sv ***
// extended control, mode and service logic of an ECP parallel port
// assumes fifo level, handshake engine and pins live outside; inputs synchronous
`timescale 1ns/1ps
`default_nettype none
module ecp_ext_ctrl #(
  parameter int DEPTH = ecp_ext_pkg::FIFO_DEPTH,
  parameter int PULSE = ecp_ext_pkg::PULSE_CYCLES
) (
  input wire logic i_clk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_ce, // clock enable
  input wire ecp_ext_pkg::reg_req_type i_req, // register access
  output logic [7:0] o_rdata, // read data
  output logic o_rdata_valid, // read data strobe
  input wire logic [3:0] i_irq_select, // chosen irq number
  input wire logic [1:0] i_dma_select, // chosen dma channel
  input wire logic i_irq_line_level, // level on the irq line
  input wire logic i_epp_option, // epp enabled in chip config
  input wire logic [3:0] i_fifo_level_setting, // programmed threshold
  input wire logic i_direction, // reverse when high
  input wire logic [4:0] i_fifo_count, // bytes held in fifo
  input wire logic i_dma_tc, // dma terminal count pulse
  input wire logic i_printer_fault_low, // fault pin
  input wire logic i_xfer_busy, // handshake engine mid-byte
  input wire ecp_ext_pkg::ctrl_lines_type i_ctrl_sw, // software control lines
  input wire ecp_ext_pkg::ctrl_lines_type i_ctrl_hw, // engine control lines
  output ecp_ext_pkg::ctrl_lines_type o_ctrl, // control line outputs
  output logic [3:0] o_ctrl_oe, // control line drive enables
  output logic o_ctrl_open_collector, // control drivers open collector
  output logic o_data_tristate, // release the data lines
  output logic o_data_read_pins, // data reads return pins
  output logic o_fifo_reset, // hold fifo reset
  output logic o_fifo_discard, // flush fifo pulse
  output logic o_fifo_host_access, // fifo reachable at 400h
  output logic o_auto_compat, // compatibility engine runs
  output logic o_auto_ecp, // ecp engine runs
  output logic o_ecp_reverse_fill, // reverse bytes to data queue
  output logic o_epp_active, // epp operation selected
  output logic o_xfer_start, // engine start pulse
  output logic o_dma_request_enable, // dma may request
  output logic o_irq_out, // irq line driven value
  output logic o_irq_oe // irq line drive enable
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [2:0] mode_r;
  logic fault_en_low_r;
  logic dma_en_r;
  logic service_r;
  logic fault_prev_r;
  logic [$clog2(PULSE+1)-1:0] pulse_cnt_r;
  logic [7:0] rdata_r;
  logic rdata_valid_r;
  logic discard_r;
  logic start_r;
  logic auto_feed_kill_r;
  logic [4:0] threshold;
  logic [4:0] free_space;
  logic service_cond;
  logic fault_event;
  logic ext_wr;
  logic [2:0] new_mode;
  logic mode_ok;
  logic [2:0] irq_code;
  logic [2:0] dma_code;
  logic [7:0] ext_read;
  logic [7:0] cfg_b_read;
  ecp_ext_pkg::mode_type mode;
  logic fifo_hold;
  logic dir_honoured;
  logic [3:0] ctrl_bits;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];
  assign mode = ecp_ext_pkg::mode_type'(mode_r);

  assign threshold = {1'b0, i_fifo_level_setting} + 5'h01;
  assign free_space = 5'(DEPTH) - i_fifo_count;
  always_comb begin
    service_cond = 1'b0;
    if (dma_en_r) begin
      service_cond = i_dma_tc;
    end else if (!i_direction) begin
      service_cond = free_space >= threshold;
    end else begin
      service_cond = i_fifo_count >= threshold;
    end
  end

  assign ext_wr = i_ce && i_req.wr && i_req.addr == ecp_ext_pkg::OFS_EXT_CTRL;
  assign new_mode = i_req.wdata[ecp_ext_pkg::MODE_MSB:ecp_ext_pkg::MODE_LSB];
  assign mode_ok = mode_r == 3'h0 || mode_r == 3'h1 || new_mode == 3'h0 ||
                   new_mode == 3'h1;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= ecp_ext_pkg::MODE_RESET;
      fault_en_low_r <= ecp_ext_pkg::FAULT_EN_RESET;
      dma_en_r <= ecp_ext_pkg::DMA_EN_RESET;
    end else if (ext_wr) begin
      if (mode_ok) begin
        mode_r <= new_mode;
      end
      fault_en_low_r <= i_req.wdata[ecp_ext_pkg::FAULT_EN_BIT];
      dma_en_r <= i_req.wdata[ecp_ext_pkg::DMA_EN_BIT];
    end
  end

  // hardware set wins over a same-cycle software clear
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      service_r <= ecp_ext_pkg::SERVICE_RESET;
    end else if (i_ce) begin
      if (!service_r && service_cond) begin
        service_r <= 1'b1;
      end else if (ext_wr) begin
        service_r <= i_req.wdata[ecp_ext_pkg::SERVICE_BIT];
      end
    end
  end

  assign fault_event = mode == ecp_ext_pkg::MODE_ECP && !fault_en_low_r &&
                       fault_prev_r && !i_printer_fault_low;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_prev_r <= 1'b1;
      pulse_cnt_r <= '0;
    end else if (i_ce) begin
      fault_prev_r <= i_printer_fault_low;
      if ((!service_r && service_cond) || fault_event ||
          (ext_wr && fault_en_low_r && !i_req.wdata[ecp_ext_pkg::FAULT_EN_BIT] &&
           !i_printer_fault_low && mode == ecp_ext_pkg::MODE_ECP)) begin
        pulse_cnt_r <= ($clog2(PULSE+1))'(PULSE);
      end else if (pulse_cnt_r != '0) begin
        pulse_cnt_r <= pulse_cnt_r - 1'b1;
      end
    end
  end
  assign o_irq_out = 1'b0;
  assign o_irq_oe = pulse_cnt_r != '0;

  assign o_dma_request_enable = dma_en_r && !service_r;

  always_comb begin
    case (i_irq_select)
      4'hF: irq_code = 3'h6;
      4'hE: irq_code = 3'h5;
      4'hB: irq_code = 3'h4;
      4'hA: irq_code = 3'h3;
      4'h9: irq_code = 3'h2;
      4'h7: irq_code = 3'h1;
      4'h5: irq_code = 3'h7;
      default: irq_code = 3'h0;
    endcase
  end
  always_comb begin
    case (i_dma_select)
      2'h3: dma_code = 3'h3;
      2'h2: dma_code = 3'h2;
      2'h1: dma_code = 3'h1;
      default: dma_code = 3'h0;
    endcase
  end
  assign cfg_b_read = {1'b0, i_irq_line_level, irq_code, dma_code};
  assign ext_read = {mode_r, fault_en_low_r, dma_en_r, service_r,
                     i_fifo_count >= 5'(DEPTH), i_fifo_count == 5'h00};

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      rdata_valid_r <= 1'b0;
    end else if (i_ce) begin
      rdata_valid_r <= i_req.rd;
      if (i_req.rd) begin
        if (i_req.addr == ecp_ext_pkg::OFS_EXT_CTRL) begin
          rdata_r <= ext_read;
        end else if (mode == ecp_ext_pkg::MODE_CONFIG &&
                     i_req.addr == ecp_ext_pkg::OFS_CONFIG_A) begin
          rdata_r <= ecp_ext_pkg::CONFIG_A_VALUE;
        end else if (mode == ecp_ext_pkg::MODE_CONFIG &&
                     i_req.addr == ecp_ext_pkg::OFS_CONFIG_B) begin
          rdata_r <= cfg_b_read;
        end else begin
          rdata_r <= 8'h00;
        end
      end
    end
  end
  assign o_rdata = rdata_r;
  assign o_rdata_valid = rdata_valid_r;

  // start pulse on entry to PFIFO or ECP, discard and feed drop on leaving ECP reverse
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= 1'b0;
      discard_r <= 1'b0;
      auto_feed_kill_r <= 1'b0;
    end else if (i_ce) begin
      start_r <= ext_wr && mode_ok && (new_mode == 3'h2 || new_mode == 3'h3) &&
                 new_mode != mode_r;
      discard_r <= ext_wr && mode_ok && mode == ecp_ext_pkg::MODE_ECP &&
                   i_direction && new_mode[2:1] == 2'h0;
      // keep feed released until the engine finishes its byte
      auto_feed_kill_r <= (mode == ecp_ext_pkg::MODE_ECP && i_direction) ||
                          (auto_feed_kill_r && i_xfer_busy);
    end
  end
  assign o_xfer_start = start_r;
  assign o_fifo_discard = discard_r;

  // per-mode decode of driver style, engine and fifo ownership
  always_comb begin
    o_ctrl_open_collector = 1'b0;
    fifo_hold = 1'b0;
    dir_honoured = 1'b1;
    o_data_read_pins = 1'b0;
    o_auto_compat = 1'b0;
    o_auto_ecp = 1'b0;
    o_fifo_host_access = 1'b0;
    o_epp_active = 1'b0;
    case (mode)
      ecp_ext_pkg::MODE_SPP: begin
        o_ctrl_open_collector = 1'b1;
        fifo_hold = 1'b1;
        dir_honoured = 1'b0;
      end
      ecp_ext_pkg::MODE_BIDIR: begin
        o_data_read_pins = 1'b1;
      end
      ecp_ext_pkg::MODE_PFIFO: begin
        // direction has no effect on the data lines here, the engine always sends
        dir_honoured = 1'b0;
        o_auto_compat = 1'b1;
        o_fifo_host_access = 1'b1;
      end
      ecp_ext_pkg::MODE_ECP: begin
        o_auto_ecp = 1'b1;
        o_fifo_host_access = 1'b1;
      end
      ecp_ext_pkg::MODE_EPP: begin
        o_epp_active = i_epp_option;
      end
      ecp_ext_pkg::MODE_TEST: begin
        o_fifo_host_access = 1'b1;
      end
      default: begin
        // reserved and configuration modes: push-pull, no engine
        o_epp_active = 1'b0;
      end
    endcase
  end
  assign o_fifo_reset = fifo_hold || discard_r;
  assign o_data_tristate = i_direction && dir_honoured;
  assign o_ecp_reverse_fill = o_auto_ecp && i_direction;
  assign ctrl_bits = o_ctrl;

  // open collector lines drive only while pulling low
  for (genvar k = 0; k < 4; k++) begin : g_ctrl_drive
    assign o_ctrl_oe[k] = !o_ctrl_open_collector || !ctrl_bits[k];
  end

  // engine owns lines only in auto modes; registered feed kill avoids glitch
  always_comb begin
    o_ctrl = i_ctrl_sw;
    if (o_auto_compat || o_auto_ecp) begin
      o_ctrl = i_ctrl_hw;
    end else if (auto_feed_kill_r && i_xfer_busy) begin
      o_ctrl.auto_feed_low = 1'b1;
    end
  end
endmodule : ecp_ext_ctrl
`default_nettype wire

// *** tb/ecp_ext_printer.sv ***
// printer side: fault pin and the shared, pulled-up irq line
// bench asks for a fault level, model drives it on the clock
`timescale 1ns/1ps
`default_nettype none
module ecp_ext_printer (
  input wire logic i_clk, // clock
  input wire logic i_fault, // fault wanted
  input wire logic i_irq_out, // irq value
  input wire logic i_irq_oe, // irq drive
  output var logic o_printer_fault_low, // fault pin
  output logic o_irq_line_level // resolved line
);
  always @(posedge i_clk) o_printer_fault_low <= !i_fault;
  assign o_irq_line_level = i_irq_oe ? i_irq_out : 1'b1;
endmodule : ecp_ext_printer
`default_nettype wire

// *** tb/ecp_ext_ctrl_chk.sv ***
// port assertions for the extended control block
// bound into every ecp_ext_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module ecp_ext_ctrl_chk #(
  parameter int DEPTH = 16,
  parameter int PULSE = 5
) (
  input wire logic i_clk, // clock
  input wire logic i_nrst, // reset
  input wire logic i_ce, // enable
  input wire ecp_ext_pkg::reg_req_type i_req, // access
  input wire logic [4:0] i_fifo_count, // fill
  input wire logic [7:0] o_rdata, // data
  input wire logic o_rdata_valid, // strobe
  input wire logic o_xfer_start, // start
  input wire logic o_auto_compat, // compat
  input wire logic o_auto_ecp, // ecp
  input wire logic o_fifo_reset, // fifo reset
  input wire logic o_fifo_discard, // flush
  input wire logic o_ctrl_open_collector, // oc
  input wire logic o_data_tristate, // release
  input wire logic o_irq_out, // irq value
  input wire logic o_irq_oe // irq drive
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  int unsigned hi_r;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hi_r <= 0;
    end else begin
      hi_r <= o_irq_oe ? hi_r + 1 : 0;
    end
  end
  property p_valid; i_ce && i_req.rd |=> o_rdata_valid; endproperty
  a_valid: assert property (p_valid) else $error("read gave no strobe");
  property p_flags; i_ce && i_req.rd && i_req.addr == ecp_ext_pkg::OFS_EXT_CTRL |=>
    o_rdata[1:0] == {$past(i_fifo_count) >= DEPTH, $past(i_fifo_count) == 5'h00}; endproperty
  a_flags: assert property (p_flags) else $error("full or empty flag wrong");
  property p_start; o_xfer_start |-> (o_auto_compat || o_auto_ecp) ##1 !o_xfer_start; endproperty
  a_start: assert property (p_start) else $error("start outside auto mode");
  property p_oc; o_fifo_reset == (o_ctrl_open_collector || o_fifo_discard); endproperty
  a_oc: assert property (p_oc) else $error("open collector mode mismatch");
  property p_tri; o_data_tristate |-> !o_ctrl_open_collector; endproperty
  a_tri: assert property (p_tri) else $error("data released in mode 0");
  property p_disc; o_fifo_discard |-> !o_auto_ecp && !o_auto_compat; endproperty
  a_disc: assert property (p_disc) else $error("flush while engine runs");
  property p_len; $fell(o_irq_oe) |-> hi_r == PULSE; endproperty
  a_len: assert property (p_len) else $error("irq pulse length wrong");
  property p_low; o_irq_oe |-> hi_r < PULSE && !o_irq_out; endproperty
  a_low: assert property (p_low) else $error("irq not a low pulse");
endmodule : ecp_ext_ctrl_chk
bind ecp_ext_ctrl ecp_ext_ctrl_chk #(.DEPTH(DEPTH), .PULSE(PULSE)) u_chk (.i_clk(i_clk),
  .i_nrst(i_nrst), .i_ce(i_ce), .i_req(i_req), .i_fifo_count(i_fifo_count), .o_rdata(o_rdata),
  .o_rdata_valid(o_rdata_valid), .o_xfer_start(o_xfer_start), .o_auto_compat(o_auto_compat),
  .o_auto_ecp(o_auto_ecp), .o_fifo_reset(o_fifo_reset), .o_fifo_discard(o_fifo_discard),
  .o_ctrl_open_collector(o_ctrl_open_collector), .o_data_tristate(o_data_tristate),
  .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe));
`default_nettype wire

// *** tb/ecp_ext_ctrl_tb.sv ***
// self-checking bench for the extended control block
// printer model supplies fault pin and resolved irq line
`timescale 1ns/1ps
`default_nettype none
module ecp_ext_ctrl_tb;
  logic clk, nrst, dir, busy, tc, epp, flt, rv, irql, fl, irqo, irqoe;
  logic oc, frst, disc, host, ac, ae, rf, ea, xs, dre, ce, dtri, rpins;
  ecp_ext_pkg::reg_req_type req;
  ecp_ext_pkg::ctrl_lines_type csw, chw, ctl;
  logic [3:0] isel, lvl, ctl_oe;
  logic [1:0] dsel;
  logic [4:0] cnt;
  logic [7:0] rd_v;
  int num_errors, comparisons;
  logic [3:0] irqn [8] = '{4'hF, 4'hE, 4'hB, 4'hA, 4'h9, 4'h7, 4'h5, 4'h3};
  logic [2:0] icode [8] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h7, 3'h0};
  ecp_ext_ctrl DUT (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_req(req), .o_rdata(rd_v),
    .o_rdata_valid(rv), .i_irq_select(isel), .i_dma_select(dsel), .i_irq_line_level(irql),
    .i_epp_option(epp), .i_fifo_level_setting(lvl), .i_direction(dir), .i_fifo_count(cnt),
    .i_dma_tc(tc), .i_printer_fault_low(fl), .i_xfer_busy(busy), .i_ctrl_sw(csw),
    .i_ctrl_hw(chw), .o_ctrl(ctl), .o_ctrl_oe(ctl_oe), .o_ctrl_open_collector(oc),
    .o_data_tristate(dtri), .o_data_read_pins(rpins), .o_fifo_reset(frst), .o_fifo_discard(disc),
    .o_fifo_host_access(host), .o_auto_compat(ac), .o_auto_ecp(ae), .o_ecp_reverse_fill(rf),
    .o_epp_active(ea), .o_xfer_start(xs), .o_dma_request_enable(dre), .o_irq_out(irqo),
    .o_irq_oe(irqoe));
  ecp_ext_printer peer (.i_clk(clk), .i_fault(flt), .i_irq_out(irqo), .i_irq_oe(irqoe),
    .o_printer_fault_low(fl), .o_irq_line_level(irql));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    #1 chk("valid", {7'h0, rv}, 8'h01);
    chk("rdata", rd_v, e);
  endtask : rd
  task automatic irq(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1 seen = seen | irqoe;
    end
    chk("irq", {7'h0, seen}, {7'h0, e});
  endtask : irq
  task automatic t_cfg;
    wr(11'h402, 8'hF4);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) isel <= irqn[i];
      dsel <= i[1:0];
      rd(11'h401, {2'b01, icode[i], 1'b0, i[1:0]});
    end
    rd(11'h400, 8'h10);
    wr(11'h402, 8'h14);
  endtask : t_cfg
  task automatic t_fwd;
    @(posedge clk) lvl <= 4'hF;
    wr(11'h402, 8'h60);
    chk("start", {7'h0, xs}, 8'h01);
    chk("ecp", {7'h0, ae}, 8'h01);
    irq(1'b1);
    wr(11'h402, 8'h54);
    rd(11'h402, 8'h75);
    wr(11'h402, 8'h14);
  endtask : t_fwd
  task automatic t_rev;
    wr(11'h402, 8'h34);
    @(posedge clk) dir <= 1'b1;
    cnt <= 5'h03;
    lvl <= 4'h3;
    @(posedge clk) #1 chk("bidir", {5'h0, dtri, rpins, ctl_oe == 4'hF}, 8'h07);
    wr(11'h402, 8'h70);
    irq(1'b0);
    @(posedge clk) cnt <= 5'h04;
    irq(1'b1);
    chk("fill", {7'h0, rf}, 8'h01);
    rd(11'h402, 8'h74);
    @(posedge clk) busy <= 1'b1;
    csw.auto_feed_low <= 1'b0;
    wr(11'h402, 8'h34);
    chk("discard", {7'h0, disc}, 8'h01);
    chk("autofeed", {7'h0, ctl.auto_feed_low}, 8'h01);
    @(posedge clk) #1 chk("autofeed", {7'h0, ctl.auto_feed_low}, 8'h01);
    @(posedge clk) dir <= 1'b0;
    busy <= 1'b0;
    cnt <= 5'h00;
    csw.auto_feed_low <= 1'b1;
  endtask : t_rev
  task automatic t_fault;
    wr(11'h402, 8'h74);
    @(posedge clk) flt <= 1'b1;
    irq(1'b0);
    wr(11'h402, 8'h64);
    irq(1'b1);
    @(posedge clk) flt <= 1'b0;
    repeat (3) @(posedge clk);
    flt <= 1'b1;
    irq(1'b1);
    @(posedge clk) flt <= 1'b0;
    wr(11'h402, 8'h14);
  endtask : t_fault
  task automatic t_dma;
    wr(11'h402, 8'h58);
    chk("compat", {6'h0, ac, xs}, 8'h03);
    chk("dmareq", {7'h0, dre}, 8'h01);
    @(posedge clk) tc <= 1'b1;
    @(posedge clk) tc <= 1'b0;
    irq(1'b1);
    chk("dmareq", {7'h0, dre}, 8'h00);
    wr(11'h402, 8'h5C);
    irq(1'b0);
    wr(11'h402, 8'h14);
  endtask : t_dma
  task automatic t_ce;
    @(posedge clk) ce <= 1'b0;
    wr(11'h402, 8'h34);
    @(posedge clk) ce <= 1'b1;
    rd(11'h402, 8'h15);
  endtask : t_ce
  task automatic t_mode(input logic [7:0] d, input logic e_epp, input logic e_host);
    wr(11'h402, d);
    chk("mode", {4'h0, ea, host, ac, ae}, {4'h0, e_epp, e_host, 2'b00});
    wr(11'h402, 8'h14);
  endtask : t_mode
  initial begin
    {nrst, dir, busy, tc, epp, flt, isel, dsel, cnt, lvl} = '0;
    req = '0;
    ce = 1'b1;
    csw = '1;
    chw = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(11'h402, 8'h15);
    chk("oc", {6'h0, oc, frst}, 8'h03);
    chk("oe", {4'h0, ctl_oe}, 8'h00);
    t_cfg();
    t_fwd();
    t_rev();
    t_fault();
    t_dma();
    @(posedge clk) epp <= 1'b1;
    t_mode(8'h94, 1'b1, 1'b0);
    @(posedge clk) epp <= 1'b0;
    t_mode(8'h94, 1'b0, 1'b0);
    t_mode(8'hB4, 1'b0, 1'b0);
    t_mode(8'hD4, 1'b0, 1'b1);
    t_ce();
    end_of_test();
  end
endmodule : ecp_ext_ctrl_tb
`default_nettype wire
